/* verilog/sat_div_cfg.svh */
// constants for the saturating arithmetic and divide unit
`ifndef SAT_DIV_CFG_SVH
`define SAT_DIV_CFG_SVH
`define SD_DATA_W 32
`define SD_OP_W 4
`define SD_FLAG_RESET 1'b0
`define SD_DIV_STEPS 32
`endif

/* verilog/sat_div_pkg.sv */
// types shared by the saturating arithmetic and divide unit
`default_nettype none
package sat_div_pkg;
  typedef enum logic [3:0] {
    OP_SIGNED_DIV, OP_UNSIGNED_DIV, OP_SIGNED_SAT, OP_UNSIGNED_SAT, OP_SIGNED_HALF_SAT,
    OP_UNSIGNED_HALF_SAT, OP_WORD_ADD, OP_WORD_SUB, OP_BYTE_ADD, OP_BYTE_SUB, OP_HALF_ADD,
    OP_HALF_SUB
  } op_code_e;
endpackage
`default_nettype wire

/* verilog/serial_divider.sv */
// iterative restoring divider, signed and unsigned, truncating toward zero
`include "sat_div_cfg.svh"
`default_nettype none
module serial_divider
  import sat_div_pkg::*;
#(
  parameter int WIDTH = 32
)(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic start,
  input wire logic isSigned,
  input wire logic [WIDTH-1:0] dividend,
  input wire logic [WIDTH-1:0] divisor,
  output logic busy,
  output logic done,
  output logic [WIDTH-1:0] quotient
);
  typedef struct packed {
    logic run;
    logic fin;
    logic neg;
    logic [5:0] count;
    logic [WIDTH-1:0] rem;
    logic [WIDTH-1:0] quo;
    logic [WIDTH-1:0] den;
    logic [WIDTH-1:0] result;
  } div_state_s;

  div_state_s st;
  div_state_s next_st;
  logic [WIDTH:0] trial;

  // one quotient bit per cycle on magnitudes, sign fixed at the end
  always_comb
  begin
    next_st = st;
    next_st.fin = 1'b0;
    trial = {st.rem, st.quo[WIDTH-1]} - {1'b0, st.den};
    if (start && !st.run)
    begin
      next_st.run = 1'b1;
      next_st.count = 6'(WIDTH);
      next_st.rem = '0;
      next_st.neg = isSigned && (dividend[WIDTH-1] ^ divisor[WIDTH-1]);
      next_st.quo = (isSigned && dividend[WIDTH-1]) ? -dividend : dividend;
      next_st.den = (isSigned && divisor[WIDTH-1]) ? -divisor : divisor;
    end
    else if (st.run)
    begin
      if (!trial[WIDTH])
      begin
        next_st.rem = trial[WIDTH-1:0];
        next_st.quo = {st.quo[WIDTH-2:0], 1'b1};
      end
      else
      begin
        next_st.rem = {st.rem[WIDTH-2:0], st.quo[WIDTH-1]};
        next_st.quo = {st.quo[WIDTH-2:0], 1'b0};
      end
      next_st.count = st.count - 6'd1;
      if (st.count == 6'd1)
      begin
        next_st.run = 1'b0;
        next_st.fin = 1'b1;
        // zero divisor gives zero, magnitude then negated for sign
        if (st.den == '0)
          next_st.result = '0;
        else if (st.neg)
          next_st.result = -next_st.quo;
        else
          next_st.result = next_st.quo;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      st <= '0;
    else
      st <= next_st;
  end

  // busy through the finish cycle too, so no new result meets the quotient write
  assign busy = st.run || st.fin;
  assign done = st.fin;
  assign quotient = st.result;
endmodule // serial_divider
`default_nettype wire

/* verilog/sat_div_unit.sv */
// saturating arithmetic and divide execution unit
// Overview of operation
// - signed divide treats both operands as two's complement, writes quotient
// - unsigned divide treats both operands as unsigned, writes quotient
// - inexact quotients truncate toward zero
// - divides leave every status flag unchanged
// - signed saturate shifts, then clamps to -2^(n-1)..2^(n-1)-1
// - unsigned saturate shifts, then clamps to 0..maximum
// - width n is 1..32 signed, 0..31 unsigned
// - pre-shift is arithmetic right 1..31 or logical left 0..31
// - dual-half width is 1..16 signed, 0..15 unsigned
// - signed dual-half saturates each halfword independently
// - unsigned dual-half saturates each halfword independently
// - word add/sub clamps 32-bit signed result
// - byte lanes four 8-bit ops, half lanes two 16-bit ops
// - clamping sets sticky flag, otherwise flag unchanged
// - lane add/sub never touch the sticky flag
// - only a status write clears the sticky flag
// - sticky flag readable through status read
// - saturating ops never alter condition flags
`include "sat_div_cfg.svh"
`default_nettype none
module sat_div_unit
  import sat_div_pkg::*;
#(
  parameter int WIDTH = `SD_DATA_W
)(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic opValid,
  input wire logic [3:0] opCode,
  input wire logic [WIDTH-1:0] operandA,
  input wire logic [WIDTH-1:0] operandB,
  input wire logic [5:0] satWidth,
  input wire logic shiftRight,
  input wire logic [4:0] shiftAmount,
  input wire logic statusWrite,
  input wire logic statusWriteValue,
  output logic opReady,
  output logic resultValid,
  output logic [WIDTH-1:0] resultData,
  output logic stickySat
);
  // ==========================================================
  // state
  typedef struct packed {
    logic valid;
    logic [WIDTH-1:0] data;
    logic sticky;
  } unit_state_s;

  unit_state_s st;
  unit_state_s next_st;
  op_code_e op;
  logic divStart;
  logic divBusy;
  logic divDone;
  logic [WIDTH-1:0] divQuot;
  logic [WIDTH-1:0] satRes;
  logic satHit;
  logic laneOp;

  assign op = op_code_e'(opCode);

  // ==========================================================
  // divider; operand read only at start, so one divide at a time
  assign divStart = opValid && !divBusy && (op == OP_SIGNED_DIV || op == OP_UNSIGNED_DIV);

  serial_divider #(
    .WIDTH(WIDTH)
  ) u_div (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .start(divStart),
    .isSigned(op == OP_SIGNED_DIV),
    .dividend(operandA),
    .divisor(operandB),
    .busy(divBusy),
    .done(divDone),
    .quotient(divQuot)
  );

  // new ops wait while a divide is in flight
  assign opReady = !divBusy;

  // ==========================================================
  // saturation datapath
  function automatic logic [WIDTH:0] clamp_s(input logic signed [WIDTH+32:0] v,
                                             input logic [5:0] n);
    logic signed [WIDTH+32:0] hi;
    logic signed [WIDTH+32:0] lo;
    logic [WIDTH-1:0] r;
    hi = (WIDTH+33)'(((WIDTH+33)'(1) <<< (n - 6'd1)) - 1);
    lo = -hi - 1;
    r = v[WIDTH-1:0];
    if (v > hi)
      return {1'b1, hi[WIDTH-1:0]};
    else if (v < lo)
      return {1'b1, lo[WIDTH-1:0]};
    return {1'b0, r};
  endfunction

  function automatic logic [WIDTH:0] clamp_u(input logic signed [WIDTH+32:0] v,
                                             input logic [5:0] n);
    logic signed [WIDTH+32:0] hi;
    hi = (WIDTH+33)'(((WIDTH+33)'(1) <<< n) - 1);
    if (v < 0)
      return {1'b1, {WIDTH{1'b0}}};
    else if (v > hi)
      return {1'b1, hi[WIDTH-1:0]};
    return {1'b0, v[WIDTH-1:0]};
  endfunction

  logic signed [WIDTH+32:0] shifted;
  logic [WIDTH:0] hiHalf;
  logic [WIDTH:0] loHalf;
  logic [5:0] nSigned;
  logic [5:0] nUnsigned;
  logic [5:0] nHalfS;
  logic [5:0] nHalfU;
  logic [WIDTH-1:0] laneRes;
  logic signed [WIDTH:0] wordSum;
  logic [WIDTH:0] wordClamp;

  // widths limited to the legal range of each form
  always_comb
  begin
    nSigned = (satWidth == 6'd0) ? 6'd1 : (satWidth > 6'd32 ? 6'd32 : satWidth);
    nUnsigned = (satWidth > 6'd31) ? 6'd31 : satWidth;
    nHalfS = (satWidth == 6'd0) ? 6'd1 : (satWidth > 6'd16 ? 6'd16 : satWidth);
    nHalfU = (satWidth > 6'd15) ? 6'd15 : satWidth;
  end

  // pre-shift: right shift of 0 treated as no shift
  always_comb
  begin
    if (shiftRight)
      shifted = (WIDTH+33)'($signed(operandB)) >>> shiftAmount;
    else
      shifted = ((WIDTH+33)'($signed(operandB))) <<< shiftAmount;
  end

  // dual halfwords, each lane clamped on its own
  always_comb
  begin
    hiHalf = '0;
    loHalf = '0;
    if (op == OP_SIGNED_HALF_SAT)
    begin
      hiHalf = clamp_s((WIDTH+33)'($signed(operandB[31:16])), nHalfS);
      loHalf = clamp_s((WIDTH+33)'($signed(operandB[15:0])), nHalfS);
    end
    else
    begin
      hiHalf = clamp_u((WIDTH+33)'($signed(operandB[31:16])), nHalfU);
      loHalf = clamp_u((WIDTH+33)'($signed(operandB[15:0])), nHalfU);
    end
  end

  // word add and subtract with one extra bit to catch overflow
  always_comb
  begin
    if (op == OP_WORD_SUB)
      wordSum = (WIDTH+1)'($signed(operandA)) - (WIDTH+1)'($signed(operandB));
    else
      wordSum = (WIDTH+1)'($signed(operandA)) + (WIDTH+1)'($signed(operandB));
    wordClamp = clamp_s((WIDTH+33)'(wordSum), 6'd32);
  end

  // lane add/sub; their clamp never feeds the sticky flag
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_lane
      logic signed [8:0] bs;
      logic signed [16:0] hs;
      logic [7:0] bc;
      logic [15:0] hc;
      // byte lane with one extra bit to see the overflow
      always_comb
      begin
        if (op == OP_BYTE_SUB)
          bs = $signed({operandA[8*gi+7], operandA[8*gi+:8]})
             - $signed({operandB[8*gi+7], operandB[8*gi+:8]});
        else
          bs = $signed({operandA[8*gi+7], operandA[8*gi+:8]})
             + $signed({operandB[8*gi+7], operandB[8*gi+:8]});
      end
      // only the two low slots carry a halfword lane; no select past bit 31
      if (gi < 2)
      begin : g_half
        always_comb
        begin
          if (op == OP_HALF_SUB)
            hs = $signed({operandA[16*gi+15], operandA[16*gi+:16]})
               - $signed({operandB[16*gi+15], operandB[16*gi+:16]});
          else
            hs = $signed({operandA[16*gi+15], operandA[16*gi+:16]})
               + $signed({operandB[16*gi+15], operandB[16*gi+:16]});
        end
      end
      else
      begin : g_no_half
        assign hs = '0;
      end
      assign bc = (bs[8] != bs[7]) ? {bs[8], {7{!bs[8]}}} : bs[7:0];
      assign hc = (hs[16] != hs[15]) ? {hs[16], {15{!hs[16]}}} : hs[15:0];
    end
  endgenerate

  always_comb
  begin
    laneRes = '0;
    if (op == OP_BYTE_ADD || op == OP_BYTE_SUB)
      laneRes = {g_lane[3].bc, g_lane[2].bc, g_lane[1].bc, g_lane[0].bc};
    else
      laneRes = {g_lane[1].hc, g_lane[0].hc};
  end

  // ==========================================================
  // result select and saturation event
  always_comb
  begin
    satRes = '0;
    satHit = 1'b0;
    laneOp = 1'b0;
    unique case (op)
      OP_SIGNED_SAT:
      begin
        {satHit, satRes} = clamp_s(shifted, nSigned);
      end
      OP_UNSIGNED_SAT:
      begin
        {satHit, satRes} = clamp_u(shifted, nUnsigned);
      end
      OP_SIGNED_HALF_SAT, OP_UNSIGNED_HALF_SAT:
      begin
        satRes = {hiHalf[15:0], loHalf[15:0]};
        satHit = hiHalf[WIDTH] | loHalf[WIDTH];
      end
      OP_WORD_ADD, OP_WORD_SUB:
      begin
        {satHit, satRes} = wordClamp;
      end
      OP_BYTE_ADD, OP_BYTE_SUB, OP_HALF_ADD, OP_HALF_SUB:
      begin
        satRes = laneRes;
        laneOp = 1'b1;
      end
      default:
      begin
        satRes = '0;
      end
    endcase
  end

  // ==========================================================
  // registered result and sticky flag; only saturation and divide paths
  // exist, so condition flags are never touched
  always_comb
  begin
    next_st = st;
    next_st.valid = 1'b0;
    if (divDone)
    begin
      next_st.valid = 1'b1;
      next_st.data = divQuot;
    end
    else if (opValid && !divBusy && op != OP_SIGNED_DIV && op != OP_UNSIGNED_DIV)
    begin
      next_st.valid = 1'b1;
      next_st.data = satRes;
    end
    // explicit status write clears or sets; a same-cycle clamp wins
    if (statusWrite)
      next_st.sticky = statusWriteValue;
    if (opValid && !divBusy && satHit && !laneOp)
      next_st.sticky = 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      st <= '{valid: 1'b0, data: '0, sticky: `SD_FLAG_RESET};
    else
      st <= next_st;
  end

  assign resultValid = st.valid;
  assign resultData = st.data;
  assign stickySat = st.sticky;

  // ==========================================================
  // checks
  property p_sticky_set;
    @(posedge clk_sys) disable iff (!rstn)
      (opValid && !divBusy && satHit && !laneOp) |=> stickySat;
  endproperty
  a_sticky_set: assert property (p_sticky_set) else $error("sticky not set");

  property p_lane_keep;
    @(posedge clk_sys) disable iff (!rstn)
      (opValid && laneOp && !statusWrite) |=> stickySat == $past(stickySat);
  endproperty
  a_lane_keep: assert property (p_lane_keep) else $error("lane op moved sticky");

  property p_no_clear;
    @(posedge clk_sys) disable iff (!rstn)
      (stickySat && !statusWrite) |=> stickySat;
  endproperty
  a_no_clear: assert property (p_no_clear) else $error("sticky lost");

  property p_div_keep;
    @(posedge clk_sys) disable iff (!rstn)
      (divBusy && !statusWrite) |=> stickySat == $past(stickySat);
  endproperty
  a_div_keep: assert property (p_div_keep) else $error("divide moved sticky");

  property p_div_latency;
    @(posedge clk_sys) disable iff (!rstn)
      divStart |-> ##34 resultValid;
  endproperty
  a_div_latency: assert property (p_div_latency) else $error("divide late");

  property p_sat_result;
    @(posedge clk_sys) disable iff (!rstn)
      (opValid && !divBusy && op == OP_WORD_ADD) |=> resultValid && resultData == $past(satRes);
  endproperty
  a_sat_result: assert property (p_sat_result) else $error("word add result");

  property p_unsigned_saturate_op_range;
    @(posedge clk_sys) disable iff (!rstn)
      (opValid && op == OP_UNSIGNED_SAT) |-> satRes[WIDTH-1] == 1'b0;
  endproperty
  a_unsigned_saturate_op_range: assert property (p_unsigned_saturate_op_range) else $error("unsigned out of range");

  property p_ready;
    @(posedge clk_sys) disable iff (!rstn)
      divStart |=> !opReady [*8];
  endproperty
  a_ready: assert property (p_ready) else $error("ready during divide");
endmodule // sat_div_unit
`default_nettype wire

/* testbench/result_sink.sv */
// register-file and status-read side model that takes the unit's results
`default_nettype none
module result_sink
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic resultValid,
  input wire logic [31:0] resultData,
  input wire logic stickySat,
  output var int nWrites,
  output logic [31:0] lastWrite,
  output logic statusRead
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // write-back and status read
  // destinations are general registers only, never the stack pointer
  // or the program counter, so every result lands in a plain slot
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      nWrites <= 0;
      lastWrite <= 32'h0000_0000;
    end
    else if (resultValid)
    begin
      nWrites <= nWrites + 1;
      lastWrite <= resultData;
    end
    statusRead <= stickySat;
  end
endmodule // result_sink
`default_nettype wire

/* testbench/sat_div_unit_test.sv */
// self-checking bench for the saturating arithmetic and divide unit
`default_nettype none
module sat_div_unit_test
  import sat_div_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // signals
  logic clk_sys;
  logic rstn;
  logic opValid;
  logic [3:0] opCode;
  logic [31:0] operandA;
  logic [31:0] operandB;
  logic [5:0] satWidth;
  logic shiftRight;
  logic [4:0] shiftAmount;
  logic statusWrite;
  logic statusWriteValue;
  logic opReady;
  logic resultValid;
  logic [31:0] resultData;
  logic stickySat;
  int nWrites;
  logic [31:0] lastWrite;
  logic statusRead;
  int failures;
  int nTests;
  int base;

  sat_div_unit DUT (.clk_sys(clk_sys), .rstn(rstn), .opValid(opValid), .opCode(opCode),
    .operandA(operandA), .operandB(operandB), .satWidth(satWidth), .shiftRight(shiftRight),
    .shiftAmount(shiftAmount), .statusWrite(statusWrite),
    .statusWriteValue(statusWriteValue), .opReady(opReady), .resultValid(resultValid),
    .resultData(resultData), .stickySat(stickySat));

  result_sink sink (.clk_sys(clk_sys), .rstn(rstn), .resultValid(resultValid),
    .resultData(resultData), .stickySat(stickySat), .nWrites(nWrites),
    .lastWrite(lastWrite), .statusRead(statusRead));

  // ==========================================================
  // clock, 40 ns period
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // checking and closing
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
  begin
    nTests++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  end
  endtask

  task automatic wrap_up();
  begin
    $display("checks %0d mismatches %0d", nTests, failures);
    if (failures == 0 && nTests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask

  // ==========================================================
  // access tasks; inputs move on the falling edge only
  task automatic issue(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b,
    input logic [5:0] n, input logic sr, input logic [4:0] sh);
  begin
    @(negedge clk_sys);
    opValid = 1'b1;
    opCode = op;
    operandA = a;
    operandB = b;
    satWidth = n;
    shiftRight = sr;
    shiftAmount = sh;
    @(negedge clk_sys);
    opValid = 1'b0;
  end
  endtask

  // looked at on falling edges, where the one-cycle pulse has settled;
  // a divide shows after 34 edges, so 40 leaves a margin
  task automatic collect(input logic [31:0] expR, input logic expQ);
    int i;
  begin
    for (i = 0; i < 40; i++)
    begin
      if (resultValid === 1'b1)
        break;
      @(negedge clk_sys);
    end
    chk("resultValid", 32'h0000_0001, {31'h0000_0000, resultValid});
    chk("resultData", expR, resultData);
    chk("stickySat", {31'h0000_0000, expQ}, {31'h0000_0000, stickySat});
    @(negedge clk_sys);
    chk("resultValid pulse", 32'h0000_0000, {31'h0000_0000, resultValid});
    chk("sink write", expR, lastWrite);
    chk("status read", {31'h0000_0000, expQ}, {31'h0000_0000, statusRead});
  end
  endtask

  task automatic run(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b,
    input logic [5:0] n, input logic sr, input logic [4:0] sh, input logic [31:0] expR,
    input logic expQ);
  begin
    issue(op, a, b, n, sr, sh);
    collect(expR, expQ);
  end
  endtask

  // one-cycle status write, flag checked once it has landed
  task automatic wq(input logic v);
  begin
    @(negedge clk_sys);
    statusWrite = 1'b1;
    statusWriteValue = v;
    @(negedge clk_sys);
    statusWrite = 1'b0;
    chk("status write", {31'h0000_0000, v}, {31'h0000_0000, stickySat});
  end
  endtask

  // ==========================================================
  // watchdog, far beyond the roughly 280 cycles the tests take
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    wrap_up();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    failures = 0;
    nTests = 0;
    rstn = 1'b0;
    opValid = 1'b0;
    opCode = 4'h0;
    operandA = 32'h0000_0000;
    operandB = 32'h0000_0000;
    satWidth = 6'h00;
    shiftRight = 1'b0;
    shiftAmount = 5'h00;
    statusWrite = 1'b0;
    statusWriteValue = 1'b0;
    repeat (3) @(negedge clk_sys);
    rstn = 1'b1;
    chk("reset data", 32'h0000_0000, resultData);
    chk("reset ready", 32'h0000_0001, {31'h0000_0000, opReady});
    chk("reset sticky", 32'h0000_0000, {31'h0000_0000, stickySat});
    // lane ops clamp one or more lanes yet leave the flag clear
    run(4'h8, 32'h7F80_0102, 32'h0180_0304, 6'h00, 1'b0, 5'h00, 32'h7F80_0406, 1'b0);
    run(4'h9, 32'h8000_1000, 32'h0180_0110, 6'h00, 1'b0, 5'h00, 32'h807F_0FF0, 1'b0);
    run(4'hA, 32'h7FFF_8000, 32'h0001_FFFF, 6'h00, 1'b0, 5'h00, 32'h7FFF_8000, 1'b0);
    run(4'hB, 32'h8000_0005, 32'h0001_0007, 6'h00, 1'b0, 5'h00, 32'h8000_FFFE, 1'b0);
    // in-range values leave the flag alone
    run(4'h6, 32'h0000_0002, 32'h0000_0003, 6'h00, 1'b0, 5'h00, 32'h0000_0005, 1'b0);
    run(4'h3, 32'h0000_0000, 32'h0000_007F, 6'h08, 1'b0, 5'h00, 32'h0000_007F, 1'b0);
    run(4'h2, 32'h0000_0000, 32'h8000_0000, 6'h20, 1'b1, 5'h1F, 32'hFFFF_FFFF, 1'b0);
    run(4'h3, 32'h0000_0000, 32'h7FFF_FFFF, 6'h1F, 1'b0, 5'h00, 32'h7FFF_FFFF, 1'b0);
    // word, saturate and dual-half clamps set the flag, only a status write clears it
    run(4'h6, 32'h7FFF_FFFF, 32'h0000_0001, 6'h00, 1'b0, 5'h00, 32'h7FFF_FFFF, 1'b1);
    wq(1'b0);
    run(4'h7, 32'h8000_0000, 32'h0000_0001, 6'h00, 1'b0, 5'h00, 32'h8000_0000, 1'b1);
    wq(1'b0);
    run(4'h2, 32'h0000_0000, 32'h0000_012C, 6'h08, 1'b0, 5'h00, 32'h0000_007F, 1'b1);
    run(4'h2, 32'h0000_0000, 32'hFFFF_FFFB, 6'h01, 1'b0, 5'h00, 32'hFFFF_FFFF, 1'b1);
    run(4'h3, 32'h0000_0000, 32'hFFFF_FFFD, 6'h08, 1'b0, 5'h00, 32'h0000_0000, 1'b1);
    run(4'h3, 32'h0000_0000, 32'h0000_0010, 6'h08, 1'b0, 5'h04, 32'h0000_00FF, 1'b1);
    run(4'h3, 32'h0000_0000, 32'h0000_0005, 6'h00, 1'b0, 5'h00, 32'h0000_0000, 1'b1);
    run(4'h4, 32'h0000_0000, 32'hFE00_0200, 6'h09, 1'b0, 5'h00, 32'hFF00_00FF, 1'b1);
    run(4'h5, 32'h0000_0000, 32'h8000_7FFF, 6'h0F, 1'b0, 5'h00, 32'h0000_7FFF, 1'b1);
    run(4'h5, 32'h0000_0000, 32'h0001_0001, 6'h00, 1'b0, 5'h00, 32'h0000_0000, 1'b1);
    // divides keep a set flag, then a cleared one
    run(4'h0, 32'hFFFF_FFF9, 32'h0000_0002, 6'h00, 1'b0, 5'h00, 32'hFFFF_FFFD, 1'b1);
    run(4'h1, 32'hFFFF_FFF9, 32'h0000_0002, 6'h00, 1'b0, 5'h00, 32'h7FFF_FFFC, 1'b1);
    wq(1'b0);
    run(4'h0, 32'h0000_0007, 32'hFFFF_FFFE, 6'h00, 1'b0, 5'h00, 32'hFFFF_FFFD, 1'b0);
    run(4'h1, 32'h0000_0005, 32'h0000_0000, 6'h00, 1'b0, 5'h00, 32'h0000_0000, 1'b0);
    run(4'h0, 32'h8000_0000, 32'h0000_0000, 6'h00, 1'b0, 5'h00, 32'h0000_0000, 1'b0);
    // a clamping add offered mid-divide is ignored, not queued
    base = nWrites;
    issue(4'h1, 32'h0000_0064, 32'h0000_0007, 6'h00, 1'b0, 5'h00);
    @(negedge clk_sys);
    chk("busy ready", 32'h0000_0000, {31'h0000_0000, opReady});
    opValid = 1'b1;
    opCode = 4'h6;
    operandA = 32'h7FFF_FFFF;
    operandB = 32'h0000_0001;
    @(negedge clk_sys);
    opValid = 1'b0;
    collect(32'h0000_000E, 1'b0);
    chk("write count", base + 1, nWrites);
    wrap_up();
  end
endmodule // sat_div_unit_test
`default_nettype wire
